// [verilog/sl1c_top.sv]
// Local design decisions: strobed register access and the register offsets.
`default_nettype none

module sl1c_top import sl1c_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Configuration port
  input wire logic [3:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [31:0] cfg_rdata,
  // Instruction fetcher
  input wire logic if_req,
  input wire logic [31:0] if_addr,
  output logic if_stall,
  output logic if_valid,
  output logic [2:0] if_num,
  output logic [1:0] if_dw,
  output logic [127:0] if_data,
  // Load/store unit
  input wire logic ls_req,
  input wire logic ls_we,
  input wire logic [31:0] ls_addr,
  input wire logic [7:0] ls_be,
  input wire logic [63:0] ls_wdata,
  input wire logic ls_wt,
  input wire logic ls_ci,
  input wire logic ls_coh,
  input wire logic ls_grd,
  input wire logic ls_spec,
  output logic ls_stall,
  output logic ls_rvalid,
  output logic [63:0] ls_rdata,
  // Block invalidate
  input wire logic ic_binv,
  input wire logic dc_binv,
  input wire logic [31:0] binv_addr,
  // Snoop
  input wire logic snp_valid,
  input wire logic [31:0] snp_addr,
  input wire logic snp_kill,
  output logic snp_hit,
  output logic snp_retry,
  // System bus
  output logic bus_req,
  output logic [1:0] bus_op,
  output logic bus_burst,
  output logic bus_glb,
  output logic [31:0] bus_addr,
  output logic [7:0] bus_be,
  output logic [63:0] bus_wdata,
  input wire logic bus_ack,
  input wire logic [63:0] bus_rdata,
  input wire logic bus_shared
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] cfg;
    sl1c_st_t st;
    logic fic;
    logic fwd;
    logic glb;
    logic shr;
    logic [1:0] way;
    logic [31:0] addr;
    logic [1:0] beat;
    logic bv;
    logic blast;
    logic [1:0] bdw;
    logic [63:0] bd;
    logic wbv;
    logic [31:0] wba;
    logic [255:0] wbd;
    logic [63:0] sdat;
    logic [7:0] sbe;
    logic lsv;
    logic [63:0] lsd;
    logic ifv;
    logic [2:0] ifn;
    logic [1:0] ifdw;
    logic [127:0] ifd;
    logic sh;
    logic srt;
    logic [31:0] rd;
  } sl1c_state_t;

  sl1c_state_t r, n;

  logic [63:0] ic_mem [LINES*DW_PER_LINE];
  logic [63:0] dc_mem [LINES*DW_PER_LINE];
  logic [TAG_W-1:0] ic_tag [LINES];
  logic [TAG_W-1:0] dc_tag [LINES];
  logic [LINES-1:0] ic_vld;
  sl1c_mesi_t dc_st [LINES];
  logic [7:0] ic_age [SETS];
  logic [7:0] dc_age [SETS];

  // ****************************************
  // Replacement helpers
  // ****************************************
  function automatic logic [1:0] vict(input logic [7:0] age, input logic [3:0] v);
    logic [1:0] w;
    w = 2'h0;
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (age[2*i+:2] == 2'h3) begin
        w = 2'(i);
      end
    end
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (!v[i]) begin
        w = 2'(i);
      end
    end
    return w;
  endfunction

  function automatic logic [7:0] touch(input logic [7:0] age, input logic [1:0] w);
    logic [7:0] t;
    logic [1:0] a;
    t = age;
    a = age[{w, 1'b0}+:2];
    for (int i = 0; i < WAYS; i++) begin
      if (2'(i) == w) begin
        t[2*i+:2] = 2'h0;
      end else if (age[2*i+:2] < a) begin
        t[2*i+:2] = 2'(age[2*i+:2] + 2'h1);
      end
    end
    return t;
  endfunction

  // ****************************************
  // Tag lookups
  // ****************************************
  logic [31:0] ia, da;
  logic [6:0] iset, dset, sset;
  logic [TAG_W-1:0] itag, dtag, stag;
  logic ihit, dhit, shit;
  logic [1:0] ihw, dhw, shw;
  logic [3:0] ivs, dvs;
  sl1c_mesi_t dcur, scur, vst;

  assign ia = ic_binv ? binv_addr : if_addr;
  assign da = dc_binv ? binv_addr : ls_addr;
  assign iset = ia[TAG_LSB-1:SET_LSB];
  assign dset = da[TAG_LSB-1:SET_LSB];
  assign sset = snp_addr[TAG_LSB-1:SET_LSB];
  assign itag = ia[31:TAG_LSB];
  assign dtag = da[31:TAG_LSB];
  assign stag = snp_addr[31:TAG_LSB];

  always_comb begin
    ihit = 1'b0;
    dhit = 1'b0;
    shit = 1'b0;
    ihw = 2'h0;
    dhw = 2'h0;
    shw = 2'h0;
    dcur = MESI_I;
    scur = MESI_I;
    for (int w = 0; w < WAYS; w++) begin
      ivs[w] = ic_vld[{2'(w), iset}];
      dvs[w] = dc_st[{2'(w), dset}] != MESI_I;
      if (ivs[w] && ic_tag[{2'(w), iset}] == itag) begin
        ihit = 1'b1;
        ihw = 2'(w);
      end
      if (dvs[w] && dc_tag[{2'(w), dset}] == dtag) begin
        dhit = 1'b1;
        dhw = 2'(w);
        dcur = dc_st[{2'(w), dset}];
      end
      // Second tag port for the bus side
      if (dc_st[{2'(w), sset}] != MESI_I && dc_tag[{2'(w), sset}] == stag) begin
        shit = 1'b1;
        shw = 2'(w);
        scur = dc_st[{2'(w), sset}];
      end
    end
  end

  // ****************************************
  // Control
  // ****************************************
  logic iw_tv, iw_vld, im_we, ia_we, dw_sv, dw_tagwe, ds_we, dm_we, da_we;
  logic flash_i, flash_d;
  logic [8:0] iw_idx, dw_idx, ds_idx;
  logic [TAG_W-1:0] iw_tag, dw_tag;
  logic [10:0] im_idx, dm_idx;
  logic [63:0] im_wd, dm_wd;
  logic [6:0] ia_set, da_set;
  logic [7:0] ia_val, da_val;
  sl1c_mesi_t dw_st, ds_st;
  logic free, dcach, snp_blk, dblk, iblk, lstart, lsst, isst;
  logic [1:0] ivw, dvw;

  always_comb begin
    n = r;
    n.lsv = 1'b0;
    n.ifv = 1'b0;
    n.bv = 1'b0;
    n.sh = 1'b0;
    n.srt = 1'b0;
    n.rd = 32'h0;
    {iw_tv, iw_vld, im_we, ia_we, dw_sv, dw_tagwe, ds_we, dm_we, da_we} = '0;
    iw_idx = {ihw, iset};
    iw_tag = itag;
    im_idx = {r.way, r.addr[TAG_LSB-1:SET_LSB], r.bdw};
    im_wd = r.bd;
    ia_set = iset;
    ia_val = touch(ic_age[iset], ihw);
    dw_idx = {dhw, dset};
    dw_tag = dtag;
    dw_st = MESI_I;
    ds_idx = {shw, sset};
    ds_st = snp_kill ? MESI_I : MESI_S;
    dm_idx = {dhw, dset, ls_addr[4:3]};
    dm_wd = dc_mem[{dhw, dset, ls_addr[4:3]}];
    da_set = dset;
    da_val = touch(dc_age[dset], dhw);
    ivw = vict(ic_age[iset], ivs);
    dvw = vict(dc_age[dset], dvs);
    vst = dc_st[{dvw, dset}];
    free = r.st == ST_IDLE && !r.wbv;
    dcach = r.cfg[DC_EN_BIT] && !ls_ci;
    lstart = 1'b0;
    lsst = 1'b0;
    isst = 1'b0;

    // Configuration; invalidate bits self-clear after the flash
    flash_i = r.cfg[IC_INV_BIT];
    flash_d = r.cfg[DC_INV_BIT];
    n.cfg[IC_INV_BIT] = 1'b0;
    n.cfg[DC_INV_BIT] = 1'b0;
    if (cfg_wr && cfg_addr == CFG_OFS) begin
      n.cfg = cfg_wdata & CFG_MASK;
    end
    if (cfg_rd) begin
      if (cfg_addr == CFG_OFS) begin
        n.rd = r.cfg;
      end else if (cfg_addr == STAT_OFS) begin
        n.rd[STAT_BUSY_BIT] = r.st != ST_IDLE;
        n.rd[STAT_WBV_BIT] = r.wbv;
      end
    end

    // Snoop: copy a modified block out, downgrade or kill
    snp_blk = snp_valid && shit;
    if (snp_blk) begin
      n.sh = 1'b1;
      if (scur == MESI_M) begin
        n.srt = 1'b1;
        if (!r.wbv) begin
          n.wbv = 1'b1;
          n.wba = {stag, sset, 5'h00};
          for (int k = 0; k < DW_PER_LINE; k++) begin
            n.wbd[64*k+:64] = dc_mem[{shw, sset, 2'(k)}];
          end
          ds_we = 1'b1;
        end
      end else begin
        ds_we = 1'b1;
      end
    end

    // Bus sequencer
    unique case (r.st)
      ST_IDLE: begin
        if (r.wbv) begin
          n.st = ST_PUSH;
          n.beat = 2'h0;
        end
      end
      ST_FILL: begin
        if (bus_ack) begin
          n.bv = 1'b1;
          n.bd = bus_rdata;
          n.bdw = 2'(r.addr[4:3] + r.beat);
          n.blast = r.beat == 2'h3;
          n.beat = 2'(r.beat + 2'h1);
          n.shr = r.shr || bus_shared;
          if (r.beat == 2'h3) begin
            n.st = ST_IDLE;
          end
        end
      end
      ST_PUSH: begin
        if (bus_ack) begin
          n.beat = 2'(r.beat + 2'h1);
          if (r.beat == 2'h3) begin
            n.wbv = 1'b0;
            n.st = ST_IDLE;
          end
        end
      end
      ST_SRD: begin
        if (bus_ack) begin
          n.st = ST_IDLE;
        end
      end
      ST_SWR: begin
        if (bus_ack) begin
          n.st = ST_IDLE;
        end
      end
      ST_KILL: begin
        if (bus_ack) begin
          dw_sv = 1'b1;
          dw_idx = {r.way, r.addr[TAG_LSB-1:SET_LSB]};
          dw_st = MESI_E;
          n.st = ST_IDLE;
        end
      end
    endcase

    // Forward every returned fetch beat, but only the first load beat, ahead of the array write
    if ((r.st == ST_FILL || r.st == ST_SRD) && bus_ack) begin
      if (r.fic) begin
        n.ifv = 1'b1;
        n.ifn = 3'h2;
        n.ifdw = 2'(r.addr[4:3] + r.beat);
        n.ifd = {64'h0, bus_rdata};
      end else if (r.fwd && r.beat == 2'h0) begin
        n.lsv = 1'b1;
        n.lsd = bus_rdata;
      end
    end

    // Staged fill beat enters the array one cycle later
    if (r.bv) begin
      im_we = r.fic;
      if (!r.fic) begin
        dm_we = 1'b1;
        dm_idx = im_idx;
        dm_wd = r.bd;
      end
      if (r.blast && r.fic) begin
        ia_set = r.addr[TAG_LSB-1:SET_LSB];
        ia_val = touch(ic_age[ia_set], r.way);
        ia_we = 1'b1;
        iw_tv = 1'b1;
        iw_vld = 1'b1;
        iw_idx = {r.way, ia_set};
        iw_tag = r.addr[31:TAG_LSB];
      end else if (r.blast) begin
        da_set = r.addr[TAG_LSB-1:SET_LSB];
        da_val = touch(dc_age[da_set], r.way);
        da_we = 1'b1;
        dw_sv = 1'b1;
        dw_idx = {r.way, da_set};
        dw_st = r.shr ? MESI_S : MESI_E;
      end
    end

    // Block invalidates
    if (ic_binv && ihit) begin
      iw_tv = 1'b1;
      iw_vld = 1'b0;
      iw_idx = {ihw, iset};
      iw_tag = itag;
      ia_we = 1'b0;
    end
    if (dc_binv && dhit) begin
      dw_sv = 1'b1;
      dw_idx = {dhw, dset};
      dw_st = MESI_I;
    end

    // Load/store port
    dblk = snp_blk || dc_binv || (r.bv && !r.fic) || (r.st == ST_KILL && bus_ack);
    if (ls_req) begin
      if (dblk) begin
        lsst = 1'b1;
      end else if (dhit && dcach) begin
        if (!ls_we) begin
          n.lsv = 1'b1;
          n.lsd = dc_mem[{dhw, dset, ls_addr[4:3]}];
          da_we = 1'b1;
        end else if (ls_spec) begin
          lsst = 1'b1;
        end else if (dcur == MESI_S && ls_coh) begin
          lsst = 1'b1;
          if (free) begin
            lstart = 1'b1;
            n.st = ST_KILL;
            n.glb = 1'b1;
            n.way = dhw;
            n.addr = {ls_addr[31:SET_LSB], 5'h00};
          end
        end else if (ls_wt && !free) begin
          lsst = 1'b1;
        end else begin
          for (int b = 0; b < 8; b++) begin
            if (ls_be[b]) begin
              dm_wd[8*b+:8] = ls_wdata[8*b+:8];
            end
          end
          dm_we = 1'b1;
          da_we = 1'b1;
          if (ls_wt) begin
            lstart = 1'b1;
            n.st = ST_SWR;
            n.glb = ls_coh;
            n.addr = {ls_addr[31:DW_LSB], 3'h0};
            n.sdat = ls_wdata;
            n.sbe = ls_be;
          end else begin
            dw_sv = 1'b1;
            dw_st = MESI_M;
          end
        end
      end else if (ls_spec || (ls_grd && ls_spec) || !free) begin
        lsst = 1'b1;
      end else begin
        lstart = 1'b1;
        n.glb = ls_coh;
        n.fic = 1'b0;
        n.fwd = !ls_we;
        n.shr = 1'b0;
        n.beat = 2'h0;
        n.addr = {ls_addr[31:DW_LSB], 3'h0};
        n.sdat = ls_wdata;
        n.sbe = ls_be;
        if (dcach && !r.cfg[DC_LOCK_BIT] && !(ls_we && ls_wt)) begin
          n.st = ST_FILL;
          n.way = dvw;
          lsst = ls_we;
          dw_sv = 1'b1;
          dw_tagwe = 1'b1;
          dw_idx = {dvw, dset};
          dw_st = MESI_I;
          if (vst == MESI_M) begin
            n.wbv = 1'b1;
            n.wba = {dc_tag[{dvw, dset}], dset, 5'h00};
            for (int k = 0; k < DW_PER_LINE; k++) begin
              n.wbd[64*k+:64] = dc_mem[{dvw, dset, 2'(k)}];
            end
          end
        end else begin
          n.st = ls_we ? ST_SWR : ST_SRD;
        end
      end
    end

    // Fetch port; no snoop ever reaches it
    iblk = ic_binv || (r.bv && r.fic) || lstart;
    if (if_req) begin
      if (iblk) begin
        isst = 1'b1;
      end else if (ihit && r.cfg[IC_EN_BIT]) begin
        n.ifv = 1'b1;
        n.ifn = 3'h4;
        n.ifdw = {if_addr[4], 1'b0};
        n.ifd = {ic_mem[{ihw, iset, if_addr[4], 1'b1}], ic_mem[{ihw, iset, if_addr[4], 1'b0}]};
        ia_we = 1'b1;
      end else if (!free) begin
        isst = 1'b1;
      end else begin
        n.fic = 1'b1;
        n.fwd = 1'b1;
        n.glb = 1'b0;
        n.shr = 1'b0;
        n.beat = 2'h0;
        n.addr = {if_addr[31:DW_LSB], 3'h0};
        if (r.cfg[IC_EN_BIT] && !r.cfg[IC_LOCK_BIT]) begin
          n.st = ST_FILL;
          n.way = ivw;
          iw_tv = 1'b1;
          iw_vld = 1'b0;
          iw_idx = {ivw, iset};
        end else begin
          n.st = ST_SRD;
        end
      end
    end
  end

  // ****************************************
  // Registers and arrays
  // ****************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.cfg <= CFG_RST;
      ic_vld <= '0;
      for (int i = 0; i < LINES; i++) begin
        dc_st[i] <= MESI_I;
      end
      for (int i = 0; i < SETS; i++) begin
        ic_age[i] <= AGE_RST;
        dc_age[i] <= AGE_RST;
      end
    end else begin
      r <= n;
      if (flash_i) begin
        ic_vld <= '0;
      end else if (iw_tv) begin
        ic_vld[iw_idx] <= iw_vld;
      end
      if (flash_d) begin
        for (int i = 0; i < LINES; i++) begin
          dc_st[i] <= MESI_I;
        end
      end else begin
        if (dw_sv) begin
          dc_st[dw_idx] <= dw_st;
        end
        if (ds_we) begin
          dc_st[ds_idx] <= ds_st;
        end
      end
      if (ia_we) begin
        ic_age[ia_set] <= ia_val;
      end
      if (da_we) begin
        dc_age[da_set] <= da_val;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (iw_tv) begin
      ic_tag[iw_idx] <= iw_tag;
    end
    if (dw_tagwe) begin
      dc_tag[dw_idx] <= dw_tag;
    end
    if (im_we) begin
      ic_mem[im_idx] <= im_wd;
    end
    if (dm_we) begin
      dc_mem[dm_idx] <= dm_wd;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign cfg_rdata = r.rd;
  assign if_stall = isst;
  assign if_valid = r.ifv;
  assign if_num = r.ifn;
  assign if_dw = r.ifdw;
  assign if_data = r.ifd;
  assign ls_stall = lsst;
  assign ls_rvalid = r.lsv;
  assign ls_rdata = r.lsd;
  assign snp_hit = r.sh;
  assign snp_retry = r.srt;
  assign bus_req = r.st != ST_IDLE;
  assign bus_op = r.st == ST_KILL ? OP_KILL :
    (r.st == ST_PUSH || r.st == ST_SWR) ? OP_WRITE : OP_READ;
  assign bus_burst = r.st == ST_FILL || r.st == ST_PUSH;
  assign bus_glb = r.glb;
  assign bus_addr = r.st == ST_PUSH ? r.wba : r.addr;
  assign bus_be = r.st == ST_SWR ? r.sbe : 8'hFF;
  assign bus_wdata = r.st == ST_PUSH ? r.wbd[{r.beat, 6'h00}+:64] : r.sdat;

endmodule

`default_nettype wire

// [verilog/sl1c_pkg.sv]
`default_nettype none

package sl1c_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int CACHE_BYTES = 16384;
  localparam int LINE_BYTES = 32;
  localparam int WAYS = 4;
  localparam int SETS = CACHE_BYTES / (LINE_BYTES * WAYS);
  localparam int LINES = SETS * WAYS;
  localparam int DW_PER_LINE = LINE_BYTES / 8;
  localparam int TAG_LSB = 12;
  localparam int SET_LSB = 5;
  localparam int DW_LSB = 3;
  localparam int TAG_W = 32 - TAG_LSB;

  // ****************************************
  // Configuration registers
  // ****************************************
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam int IC_EN_BIT = 16;
  localparam int DC_EN_BIT = 17;
  localparam int IC_LOCK_BIT = 18;
  localparam int DC_LOCK_BIT = 19;
  localparam int IC_INV_BIT = 20;
  localparam int DC_INV_BIT = 21;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_MASK = 32'h003F_0000;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WBV_BIT = 1;

  // Way ages after reset: way n has age n
  localparam logic [7:0] AGE_RST = 8'hE4;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {MESI_I, MESI_S, MESI_E, MESI_M} sl1c_mesi_t;
  typedef enum logic [2:0] {ST_IDLE, ST_FILL, ST_PUSH, ST_SRD, ST_SWR, ST_KILL} sl1c_st_t;
  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_KILL} sl1c_op_t;

endpackage

`default_nettype wire

// [bench/sl1c_checker.sv]
`default_nettype none

module sl1c_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Configuration port
  input wire logic [3:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [31:0] cfg_rdata,
  // Fetch and load/store
  input wire logic if_req,
  input wire logic if_stall,
  input wire logic if_valid,
  input wire logic [2:0] if_num,
  input wire logic ls_req,
  input wire logic ls_we,
  input wire logic ls_spec,
  input wire logic ls_stall,
  input wire logic ls_rvalid,
  // Snoop and bus
  input wire logic snp_valid,
  input wire logic snp_hit,
  input wire logic snp_retry,
  input wire logic bus_req,
  input wire logic [1:0] bus_op,
  input wire logic bus_burst,
  input wire logic [31:0] bus_addr,
  input wire logic [7:0] bus_be,
  input wire logic bus_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] beat_r;

  // ******
  // Beat counter of the current bus request
  // ******
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      beat_r <= 3'h0;
    end else if (!bus_req) begin
      beat_r <= 3'h0;
    end else if (bus_ack) begin
      beat_r <= beat_r + 3'h1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_rdata_idle: assert property (
    !$past(cfg_rd) |-> cfg_rdata == 32'h0) else $error("read data outside read slot");
  a_cfg_bits: assert property (
    $past(cfg_rd) && $past(cfg_addr) == 4'h0 && !$past(cfg_wr, 2)
    |-> (cfg_rdata & 32'hFFF0_FFFF) == 32'h0) else $error("config bits out of field");
  a_req_held: assert property (
    bus_req && !bus_ack |=> bus_req && $stable(bus_op)) else $error("bus request dropped");
  a_beat_count: assert property (
    $fell(bus_req) |-> beat_r == ($past(bus_burst) ? 3'h4 : 3'h1)) else $error("beat count");
  a_burst_bytes: assert property (
    bus_req && bus_burst |-> bus_be == 8'hFF && bus_op != 2'h2) else $error("burst bytes");
  a_push_align: assert property (
    bus_req && bus_burst && bus_op == 2'h1 |-> bus_addr[4:0] == 5'h0) else $error("push align");
  a_spec_store: assert property (
    ls_req && ls_we && ls_spec |-> ls_stall) else $error("speculative store taken");
  a_snoop_cause: assert property (
    snp_hit || snp_retry |-> $past(snp_valid)) else $error("snoop answer without lookup");
  a_load_cause: assert property (
    ls_rvalid |-> $past(bus_ack) || ($past(ls_req) && !$past(ls_stall) && !$past(ls_we)))
    else $error("load data without cause");
  a_fetch_width: assert property (
    if_valid |-> (if_num == 3'h4 && $past(if_req) && !$past(if_stall))
    || (if_num == 3'h2 && $past(bus_ack))) else $error("fetch width");

  c_snoop_push: cover property (snp_retry);
  c_push_burst: cover property (bus_req && bus_burst && bus_op == 2'h1);
  c_fetch_hit: cover property (if_valid && if_num == 3'h4);
endmodule

`default_nettype wire

// [bench/sl1c_bus_model.sv]
`default_nettype none

module sl1c_bus_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Bench controls
  input wire logic slow,
  input wire logic shared_in,
  // System bus
  input wire logic bus_req,
  input wire logic [1:0] bus_op,
  input wire logic bus_burst,
  input wire logic [31:0] bus_addr,
  input wire logic [63:0] bus_wdata,
  output logic bus_ack,
  output logic [63:0] bus_rdata,
  output logic bus_shared
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] mem [logic [31:0]];
  logic [31:0] ba;
  logic [31:0] wa;
  int beat;
  int dly;

  // ******
  // Memory answering beat by beat
  // ******
  assign ba = {bus_addr[31:5], bus_addr[4:3] + beat[1:0], 3'h0};

  function automatic logic [63:0] md(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : {~a, a};
  endfunction

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_ack <= 1'b0;
      bus_rdata <= 64'h0;
      bus_shared <= 1'b0;
      beat <= 0;
      dly <= 1;
    end else begin
      if (bus_ack && bus_op == 2'h1) mem[wa] = bus_wdata;
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (!bus_req) begin
        beat <= 0;
        dly <= 1;
      end else if (beat < ((bus_burst && bus_op != 2'h2) ? 4 : 1)) begin
        if (dly != 0) begin
          dly <= dly - 1;
        end else begin
          bus_ack <= 1'b1;
          bus_rdata <= md(ba);
          bus_shared <= shared_in;
          wa <= ba;
          beat <= beat + 1;
          dly <= slow ? 2 : 0;
        end
      end
    end
  end
endmodule

`default_nettype wire

// [bench/tb_split_l1_cache_mesi.sv]
`default_nettype none

module tb_split_l1_cache_mesi;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, reset_n, cfg_wr, cfg_rd, if_req, if_stall, if_valid, ls_req, ls_we, ls_spec;
  logic ls_stall, ls_rvalid, dc_binv, snp_valid, snp_kill, snp_hit, snp_retry, bus_req, ls_ci;
  logic bus_burst, bus_ack, bus_shared, slow, shared_in, bus_q, burst_q;
  logic [1:0] if_dw, bus_op, op_q;
  logic [2:0] if_num;
  logic [3:0] cfg_addr;
  logic [7:0] ls_be, bus_be;
  logic [31:0] cfg_wdata, cfg_rdata, if_addr, ls_addr, binv_addr, snp_addr, bus_addr, addr_q;
  logic [63:0] ls_wdata, ls_rdata, bus_wdata, bus_rdata;
  logic [127:0] if_data;
  int error_cnt, checks, nbus;

  sl1c_top sl1c_top_inst (.ref_clk, .reset_n, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd,
    .cfg_rdata, .if_req, .if_addr, .if_stall, .if_valid, .if_num, .if_dw, .if_data, .ls_req,
    .ls_we, .ls_addr, .ls_be, .ls_wdata, .ls_wt(1'b0), .ls_ci, .ls_coh(1'b1),
    .ls_grd(1'b0), .ls_spec, .ls_stall, .ls_rvalid, .ls_rdata, .ic_binv(1'b0), .dc_binv,
    .binv_addr, .snp_valid, .snp_addr, .snp_kill, .snp_hit, .snp_retry, .bus_req, .bus_op,
    .bus_burst, .bus_glb(), .bus_addr, .bus_be, .bus_wdata, .bus_ack, .bus_rdata, .bus_shared);
  sl1c_bus_model sl1c_bus_model_inst (.ref_clk, .reset_n, .slow, .shared_in, .bus_req,
    .bus_op, .bus_burst, .bus_addr, .bus_wdata, .bus_ack, .bus_rdata, .bus_shared);

  // ******
  // Clock, bus monitor and tasks
  // ******
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    bus_q <= bus_req;
    if (bus_req && !bus_q) begin
      nbus <= nbus + 1;
      {burst_q, op_q, addr_q} <= {bus_burst, bus_op, bus_addr};
    end
  end

  function automatic logic [63:0] md(input logic [31:0] a);
    return {~a, a};
  endfunction

  task automatic report_and_stop;
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkb(input string n, input logic e, input logic g);
    chk(n, {63'h0, e}, {63'h0, g});
  endtask

  task automatic waitfor(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (s !== v && n < 200);
    if (s !== v) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [31:0] d);
    cfg_addr <= 4'h0;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge ref_clk);
    cfg_rd <= 1'b0;
    @(negedge ref_clk);
    chk("cfg_rdata", {32'h0, e}, {32'h0, cfg_rdata});
    @(posedge ref_clk);
  endtask

  task automatic ls(input logic w, input logic [31:0] a, input logic [63:0] d, input logic m);
    int b;
    b = nbus;
    ls_req <= 1'b1;
    ls_we <= w;
    ls_addr <= a;
    ls_wdata <= d;
    waitfor(ls_stall, 1'b0);
    @(posedge ref_clk);
    ls_req <= 1'b0;
    if (!w) begin
      waitfor(ls_rvalid, 1'b1);
      chk("ls_rdata", d, ls_rdata);
    end
    waitfor(bus_req, 1'b0);
    chkb("miss", m, nbus != b);
    @(posedge ref_clk);
  endtask

  task automatic snoop(input logic [31:0] a, input logic r);
    snp_valid <= 1'b1;
    snp_addr <= a;
    snp_kill <= 1'b1;
    @(posedge ref_clk);
    snp_valid <= 1'b0;
    @(negedge ref_clk);
    chkb("snp_hit", 1'b1, snp_hit);
    chkb("snp_retry", r, snp_retry);
    @(posedge ref_clk);
  endtask

  task automatic fetch(input logic [31:0] a, input logic [2:0] e);
    if_req <= 1'b1;
    if_addr <= a;
    waitfor(if_stall, 1'b0);
    @(posedge ref_clk);
    if_req <= 1'b0;
    waitfor(if_valid, 1'b1);
    chk("if_num", {61'h0, e}, {61'h0, if_num});
    chk("if_data", md({a[31:5], if_dw, 3'h0}), if_data[63:0]);
    if (e == 3'h4) begin
      chk("if_data_hi", md({a[31:5], if_dw + 2'h1, 3'h0}), if_data[127:64]);
    end
    @(posedge ref_clk);
  endtask

  // ******
  // Main sequence
  // ******
  initial begin
    {reset_n, cfg_wr, cfg_rd, if_req, ls_req, ls_we, ls_spec, dc_binv} = '0;
    {snp_valid, snp_kill, slow, shared_in, ls_ci} = '0;
    {cfg_addr, cfg_wdata, if_addr, ls_addr, ls_wdata, binv_addr, snp_addr} = '0;
    ls_be = 8'hFF;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    wr(32'hFFFF_FFFF);
    rd(4'h0, 32'h003F_0000);
    rd(4'h0, 32'h000F_0000);
    wr(32'h0003_0000);
    ls(1'b0, 32'h1018, md(32'h1018), 1'b1);
    chkb("burst", 1'b1, burst_q);
    chk("bus_addr", 64'h1018, {32'h0, addr_q});
    ls(1'b0, 32'h1000, md(32'h1000), 1'b0);
    for (int i = 2; i < 6; i++) begin
      ls(1'b0, (32'(i) << 12) | 32'h20, md((32'(i) << 12) | 32'h20), 1'b1);
    end
    ls(1'b0, 32'h2020, md(32'h2020), 1'b0);
    ls(1'b0, 32'h6020, md(32'h6020), 1'b1);
    ls(1'b0, 32'h2020, md(32'h2020), 1'b0);
    ls(1'b0, 32'h3020, md(32'h3020), 1'b1);
    {slow, shared_in} <= 2'b11;
    ls(1'b0, 32'h7040, md(32'h7040), 1'b1);
    shared_in <= 1'b0;
    ls(1'b1, 32'h7040, 64'hA5, 1'b1);
    chk("bus_op", 64'h2, {62'h0, op_q});
    slow <= 1'b0;
    snoop(32'h7040, 1'b1);
    ls(1'b0, 32'h7040, 64'hA5, 1'b1);
    snoop(32'h2020, 1'b0);
    ls(1'b0, 32'h2020, md(32'h2020), 1'b1);
    wr(32'h000B_0000);
    ls(1'b0, 32'h8060, md(32'h8060), 1'b1);
    chkb("burst", 1'b0, burst_q);
    ls(1'b0, 32'h8060, md(32'h8060), 1'b1);
    wr(32'h0003_0000);
    for (int k = 0; k < 2; k++) begin
      {ls_spec, ls_req, ls_we, ls_addr} <= {2'b11, 1'(k), 32'h9000};
      repeat (4) @(negedge ref_clk);
      chkb("ls_stall", 1'b1, ls_stall);
      chkb("bus_req", 1'b0, bus_req);
      @(posedge ref_clk);
      {ls_spec, ls_req} <= 2'b0;
      @(posedge ref_clk);
    end
    ls(1'b0, 32'h9000, md(32'h9000), 1'b1);
    ls_ci <= 1'b1;
    ls(1'b0, 32'h9000, md(32'h9000), 1'b1);
    chkb("burst", 1'b0, burst_q);
    ls_ci <= 1'b0;
    wr(32'h0023_0000);
    @(posedge ref_clk);
    ls(1'b0, 32'h3020, md(32'h3020), 1'b1);
    {binv_addr, dc_binv} <= {32'h3020, 1'b1};
    @(posedge ref_clk);
    dc_binv <= 1'b0;
    ls(1'b0, 32'h3020, md(32'h3020), 1'b1);
    fetch(32'h0908, 3'h2);
    chk("bus_addr", 64'h0908, {32'h0, addr_q});
    fetch(32'h0900, 3'h4);
    report_and_stop();
  end
endmodule

bind sl1c_top sl1c_checker sl1c_checker_inst (.ref_clk, .reset_n, .cfg_addr, .cfg_wr,
  .cfg_rd, .cfg_rdata, .if_req, .if_stall, .if_valid, .if_num, .ls_req, .ls_we, .ls_spec,
  .ls_stall, .ls_rvalid, .snp_valid, .snp_hit, .snp_retry, .bus_req, .bus_op, .bus_burst,
  .bus_addr, .bus_be, .bus_ack);

`default_nettype wire
